//--- src/ghp_defines.svh
// Constants of the generic host bus port: timing counts and field positions.
// Assumes both ends run on the same 10 MHz clock rate.
`ifndef GHP_DEFINES_SVH
`define GHP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define GHP_MCLK_PERIOD_NS 100
`define GHP_BUS_CLOCK_PERIOD_NS 800
`define GHP_BUS_CLOCK_HALF_CYC ((`GHP_BUS_CLOCK_PERIOD_NS / `GHP_MCLK_PERIOD_NS) / 2)
`define GHP_CAPTURE_EDGE 3'h4
`define GHP_GAP_FALLS 2'h2

// ----------------------------------------------------------------------------
// Widths and lanes
// ----------------------------------------------------------------------------
`define GHP_ADDR_W 17
`define GHP_DATA_W 16
`define GHP_BE_WORD 2'h3
`define GHP_BE_LOW 2'h1
`define GHP_BE_HIGH 2'h2

`endif

//--- src/ghp_pkg.sv
// Types shared by both ends of the generic host bus port.
// Assumes ghp_defines.svh sits on the include path.
package ghp_pkg;

    // ------------------------------------------------------------------------
    // Bus modes and state machines
    // ------------------------------------------------------------------------
    typedef enum logic {GHP_MODE_SPLIT, GHP_MODE_SINGLE} ghp_mode_t;
    typedef enum logic [1:0] {GHP_DEV_IDLE, GHP_DEV_ACT, GHP_DEV_HOLD} ghp_dev_state_t;
    typedef enum logic [2:0] {GHP_HOST_IDLE, GHP_HOST_SETUP, GHP_HOST_STROBE, GHP_HOST_WAIT,
                              GHP_HOST_GAP} ghp_host_state_t;

endpackage : ghp_pkg

//--- src/ghp_if.sv
// Pins of the generic host bus port between the host and the device.
// Assumes the bench joins both ends here; wait has a pull-up, data floats high.
`timescale 1ns/100ps
interface ghp_if;
    logic host_bus_clock;
    logic cs_n;
    logic [16:0] addr;
    logic mem_reg_sel;
    logic read_strobe_lo_n;
    logic read_strobe_hi_n;
    logic write_strobe_lo_n;
    logic write_strobe_hi_n;
    logic read_n;
    logic write_n;
    logic high_byte_enable_n;
    logic [15:0] host_data_o;
    logic host_data_oe;
    logic [15:0] dev_data_o;
    logic dev_data_oe;
    logic wait_n_o;
    logic wait_n_oe;
    logic [15:0] data;
    logic wait_n;

    // ------------------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------------------
    assign data = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 16'hffff);
    assign wait_n = wait_n_oe ? wait_n_o : 1'h1;

    modport dev (input host_bus_clock, cs_n, addr, mem_reg_sel, read_strobe_lo_n, read_strobe_hi_n,
                 write_strobe_lo_n, write_strobe_hi_n, read_n, write_n, high_byte_enable_n, data,
                 output dev_data_o, dev_data_oe, wait_n_o, wait_n_oe);
    modport host (output host_bus_clock, cs_n, addr, mem_reg_sel, read_strobe_lo_n, read_strobe_hi_n,
                  write_strobe_lo_n, write_strobe_hi_n, read_n, write_n, high_byte_enable_n,
                  host_data_o, host_data_oe, input data, wait_n);
endinterface : ghp_if

//--- src/ghp_device.sv
// Device end of the generic host bus port: turns host accesses into word requests.
// Assumes the host keeps its own timing and the internal side answers each request with i_ack.
//
// What this block does
// (R1) Split mode: access starts at qualified clock edge.
// (R2) Split mode: wait driven low on strobe change.
// (R3) Split mode: host holds strobes until wait high.
// (R4) Split mode: wait floated soon after strobes rise.
// (R5) Split mode: write data taken at fourth edge.
// (R6) Split mode: read data driven only while strobed.
// (R7) Split mode: host holds address and select.
// (R8) Split mode: strobes high one clock between accesses.
// (R9) Little endian: strobe pair picks byte lanes.
// (R10) Big endian: strobe zero low lane, one high.
// (R11) Split mode: address bit zero ignored; accesses word aligned.
// (R12) Single mode: access starts at qualified clock edge.
// (R13) Single mode: write data taken at fourth edge.
// (R14) Single mode: wait floated soon after strobe rises.
// (R15) Single mode: strobes high one clock between accesses.
// (R16) Single mode: enable and bit zero pick lanes.
// (R17) Single mode is little endian only.
// (R18) Wait released only after data valid or accepted.
`timescale 1ns/100ps
`include "ghp_defines.svh"
module ghp_device (
    input wire logic i_mclk,
    input wire logic i_rst,
    ghp_if.dev bus,
    input wire ghp_pkg::ghp_mode_t i_mode,
    input wire logic i_big_endian,
    output logic o_req_q,
    output logic o_wr_q,
    output logic [15:0] o_addr_q,
    output logic o_mem_sel_q,
    output logic [1:0] o_be_q,
    output logic [15:0] o_wdata_q,
    input wire logic i_ack,
    input wire logic [15:0] i_rdata
);
    import ghp_pkg::*;

    localparam int SYNC_W = 27 + `GHP_DATA_W;

    // ------------------------------------------------------------------------
    // Byte lane decode
    // ------------------------------------------------------------------------
    // Lanes follow the strobes or the enable; the big endian flag only renames
    // addresses, so the lanes of both orders are the same.
    function automatic logic [1:0] lanes(input ghp_mode_t mode, input logic lo_n, input logic hi_n,
                                         input logic bhe_n, input logic a0);
        logic [1:0] be;
        be = 2'h0;
        if (mode == GHP_MODE_SPLIT) begin
            be = {~hi_n, ~lo_n}; // R9 R10
        end else if (!bhe_n && !a0) begin // R16 R17
            be = `GHP_BE_WORD;
        end else if (bhe_n && !a0) begin
            be = `GHP_BE_LOW;
        end else if (!bhe_n && a0) begin
            be = `GHP_BE_HIGH;
        end
        return be;
    endfunction : lanes

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic clk_dly_q;

    assign pins = {bus.host_bus_clock, bus.cs_n, bus.read_strobe_lo_n, bus.read_strobe_hi_n,
                   bus.write_strobe_lo_n, bus.write_strobe_hi_n, bus.read_n, bus.write_n,
                   bus.high_byte_enable_n, bus.mem_reg_sel, bus.addr, bus.data};

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '1;
            sync_q <= '1;
            clk_dly_q <= 1'h1;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
            clk_dly_q <= sync_q[SYNC_W-1];
        end
    end

    logic s_clk;
    logic s_cs_n;
    logic s_rlo_n;
    logic s_rhi_n;
    logic s_wlo_n;
    logic s_whi_n;
    logic s_rd_n;
    logic s_wr_n;
    logic s_bhe_n;
    logic s_msel;
    logic [16:0] s_addr;
    logic [15:0] s_data;

    assign {s_clk, s_cs_n, s_rlo_n, s_rhi_n, s_wlo_n, s_whi_n, s_rd_n, s_wr_n, s_bhe_n, s_msel,
            s_addr, s_data} = sync_q;

    logic clk_rise;
    logic rd_any;
    logic wr_any;
    logic stb_any;

    assign clk_rise = s_clk & ~clk_dly_q;
    assign rd_any = (i_mode == GHP_MODE_SPLIT) ? (~s_rlo_n | ~s_rhi_n) : ~s_rd_n;
    assign wr_any = (i_mode == GHP_MODE_SPLIT) ? (~s_wlo_n | ~s_whi_n) : ~s_wr_n;
    assign stb_any = rd_any | wr_any;

    // ------------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------------
    ghp_dev_state_t state_q;
    logic [2:0] edges_q;
    logic got_q;
    logic wait_oe_q;
    logic wait_o_q;
    logic data_oe_q;
    logic [15:0] dout_q;
    logic unused_be;

    assign unused_be = i_big_endian;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= GHP_DEV_IDLE;
            edges_q <= 3'h0;
            got_q <= 1'h0;
            wait_oe_q <= 1'h0;
            wait_o_q <= 1'h0;
            data_oe_q <= 1'h0;
            dout_q <= 16'h0;
            o_req_q <= 1'h0;
            o_wr_q <= 1'h0;
            o_addr_q <= 16'h0;
            o_mem_sel_q <= 1'h0;
            o_be_q <= 2'h0;
            o_wdata_q <= 16'h0;
        end else begin
            o_req_q <= 1'h0;
            unique case (state_q)
                GHP_DEV_IDLE: begin
                    wait_o_q <= 1'h0;
                    wait_oe_q <= ~s_cs_n & stb_any; // R2
                    got_q <= 1'h0;
                    if (clk_rise && !s_cs_n && stb_any) begin // R1 R12
                        state_q <= GHP_DEV_ACT;
                        edges_q <= 3'h1;
                        o_wr_q <= wr_any;
                        o_addr_q <= s_addr[16:1]; // R11
                        o_mem_sel_q <= s_msel;
                        o_be_q <= wr_any ? lanes(i_mode, s_wlo_n, s_whi_n, s_bhe_n, s_addr[0])
                                         : lanes(i_mode, s_rlo_n, s_rhi_n, s_bhe_n, s_addr[0]);
                        o_req_q <= ~wr_any;
                        data_oe_q <= ~wr_any; // R6
                    end
                end
                GHP_DEV_ACT: begin
                    wait_oe_q <= 1'h1;
                    if (clk_rise && edges_q < `GHP_CAPTURE_EDGE) begin
                        edges_q <= edges_q + 3'h1;
                    end
                    if (clk_rise && o_wr_q && edges_q == `GHP_CAPTURE_EDGE - 3'h1) begin
                        o_wdata_q <= s_data; // R5 R13
                        o_req_q <= 1'h1;
                    end
                    if (i_ack) begin
                        got_q <= 1'h1;
                        if (!o_wr_q) begin
                            dout_q <= i_rdata;
                        end
                    end
                    if (!stb_any) begin
                        state_q <= GHP_DEV_IDLE;
                        wait_oe_q <= 1'h0;
                        data_oe_q <= 1'h0;
                    end else if (got_q && edges_q == `GHP_CAPTURE_EDGE) begin
                        wait_o_q <= 1'h1; // R18
                        state_q <= GHP_DEV_HOLD;
                    end
                end
                GHP_DEV_HOLD: begin
                    if (!stb_any) begin // R3
                        wait_oe_q <= 1'h0; // R4 R14
                        data_oe_q <= 1'h0; // R6
                        state_q <= GHP_DEV_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------------
    assign bus.wait_n_o = wait_o_q;
    assign bus.wait_n_oe = wait_oe_q;
    assign bus.dev_data_o = dout_q;
    assign bus.dev_data_oe = data_oe_q;

endmodule : ghp_device

//--- src/ghp_host.sv
// Host end of the generic host bus port: runs one access per user request.
// Assumes the device answers on the wait line as the bus modes require.
`timescale 1ns/100ps
`include "ghp_defines.svh"
module ghp_host (
    input wire logic i_mclk,
    input wire logic i_rst,
    ghp_if.host bus,
    input wire ghp_pkg::ghp_mode_t i_mode,
    input wire logic i_big_endian,
    input wire logic i_req,
    input wire logic i_wr,
    input wire logic [16:0] i_addr,
    input wire logic i_mem_sel,
    input wire logic [1:0] i_be,
    input wire logic [15:0] i_wdata,
    output logic o_busy_q,
    output logic o_done_q,
    output logic [15:0] o_rdata_q
);
    import ghp_pkg::*;

    // ------------------------------------------------------------------------
    // Bus clock divider
    // ------------------------------------------------------------------------
    logic [3:0] div_q;
    logic bclk_q;
    logic fall_en;

    assign fall_en = (div_q == 4'(`GHP_BUS_CLOCK_HALF_CYC - 1)) && bclk_q;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            div_q <= 4'h0;
            bclk_q <= 1'h0;
        end else if (div_q == 4'(`GHP_BUS_CLOCK_HALF_CYC - 1)) begin
            div_q <= 4'h0;
            bclk_q <= ~bclk_q;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Wait and data synchronisers
    // ------------------------------------------------------------------------
    logic [16:0] meta_q;
    logic [16:0] sync_q;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= {bus.wait_n, bus.data};
            sync_q <= meta_q;
        end
    end

    // ------------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------------
    ghp_host_state_t state_q;
    logic wr_q;
    logic [1:0] be_q;
    logic seen_low_q;
    logic [1:0] gap_q;
    logic cs_n_q;
    logic [16:0] addr_q;
    logic msel_q;
    logic [3:0] stb_n_q;
    logic bhe_n_q;
    logic [15:0] dout_q;
    logic dout_oe_q;
    logic a0;

    // Little endian puts the lone high byte at the odd address; big endian the low one.
    assign a0 = (i_mode == GHP_MODE_SINGLE || !i_big_endian) ? (i_be == `GHP_BE_HIGH)
                                                             : (i_be == `GHP_BE_LOW);

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= GHP_HOST_IDLE;
            wr_q <= 1'h0;
            be_q <= 2'h0;
            seen_low_q <= 1'h0;
            gap_q <= 2'h0;
            cs_n_q <= 1'h1;
            addr_q <= 17'h0;
            msel_q <= 1'h0;
            stb_n_q <= 4'hf;
            bhe_n_q <= 1'h1;
            dout_q <= 16'h0;
            dout_oe_q <= 1'h0;
            o_busy_q <= 1'h0;
            o_done_q <= 1'h0;
            o_rdata_q <= 16'h0;
        end else begin
            o_done_q <= 1'h0;
            unique case (state_q)
                GHP_HOST_IDLE: begin
                    if (i_req) begin
                        o_busy_q <= 1'h1;
                        wr_q <= i_wr;
                        be_q <= i_be;
                        addr_q <= {i_addr[16:1], a0};
                        msel_q <= i_mem_sel;
                        bhe_n_q <= ~i_be[1];
                        dout_q <= i_wdata;
                        state_q <= GHP_HOST_SETUP;
                    end
                end
                GHP_HOST_SETUP: begin
                    if (fall_en) begin
                        cs_n_q <= 1'h0;
                        dout_oe_q <= wr_q;
                        state_q <= GHP_HOST_STROBE;
                    end
                end
                GHP_HOST_STROBE: begin
                    if (fall_en) begin
                        if (i_mode == GHP_MODE_SPLIT) begin
                            stb_n_q <= wr_q ? {2'h3, ~be_q} : {~be_q, 2'h3};
                        end else begin
                            stb_n_q <= wr_q ? 4'he : 4'hd;
                        end
                        seen_low_q <= 1'h0;
                        state_q <= GHP_HOST_WAIT;
                    end
                end
                GHP_HOST_WAIT: begin
                    if (!sync_q[16]) begin
                        seen_low_q <= 1'h1;
                    end
                    if (seen_low_q && sync_q[16] && fall_en) begin // R3
                        stb_n_q <= 4'hf;
                        o_rdata_q <= sync_q[15:0];
                        gap_q <= 2'h0;
                        state_q <= GHP_HOST_GAP;
                    end
                end
                GHP_HOST_GAP: begin
                    if (fall_en) begin
                        cs_n_q <= 1'h1; // R7
                        dout_oe_q <= 1'h0;
                        gap_q <= gap_q + 2'h1;
                        if (gap_q == `GHP_GAP_FALLS - 2'h1) begin // R8 R15
                            o_busy_q <= 1'h0;
                            o_done_q <= 1'h1;
                            state_q <= GHP_HOST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------------
    // Split mode uses bits 3..0 as read hi, read lo, write hi, write lo;
    // single mode uses bit 1 as read and bit 0 as write.
    assign bus.host_bus_clock = bclk_q;
    assign bus.cs_n = cs_n_q;
    assign bus.addr = addr_q;
    assign bus.mem_reg_sel = msel_q;
    assign bus.read_strobe_hi_n = (i_mode == GHP_MODE_SPLIT) ? stb_n_q[3] : 1'h1;
    assign bus.read_strobe_lo_n = (i_mode == GHP_MODE_SPLIT) ? stb_n_q[2] : 1'h1;
    assign bus.write_strobe_hi_n = stb_n_q[1];
    assign bus.write_strobe_lo_n = stb_n_q[0];
    assign bus.read_n = (i_mode == GHP_MODE_SINGLE) ? stb_n_q[1] : 1'h1;
    assign bus.write_n = (i_mode == GHP_MODE_SINGLE) ? stb_n_q[0] : 1'h1;
    assign bus.high_byte_enable_n = bhe_n_q;
    assign bus.host_data_o = dout_q;
    assign bus.host_data_oe = dout_oe_q;

endmodule : ghp_host

//--- dv/ghp_asserts.sv
// Pin checker for the generic host bus port.
// Assumes the testbench instantiates it beside the interface joining both ends.
`timescale 1ns/100ps
module ghp_asserts (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic host_bus_clock,
    input wire logic cs_n,
    input wire logic [16:0] addr,
    input wire logic mem_reg_sel,
    input wire logic high_byte_enable_n,
    input wire logic read_strobe_lo_n,
    input wire logic read_strobe_hi_n,
    input wire logic write_strobe_lo_n,
    input wire logic write_strobe_hi_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic wait_n_o,
    input wire logic wait_n_oe,
    input wire logic dev_data_oe,
    input wire logic wait_n
);
    logic strb;
    logic rstrb;
    logic [2:0] edge_q;

    assign strb = ~&{read_strobe_lo_n, read_strobe_hi_n, write_strobe_lo_n, write_strobe_hi_n, read_n, write_n};
    assign rstrb = ~&{read_strobe_lo_n, read_strobe_hi_n, read_n};

    // ------------------------------------------------------------------------
    // Bus clock rises seen since the strobes fell
    // ------------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            edge_q <= 3'h0;
        end else if (!strb) begin
            edge_q <= 3'h0;
        end else if ($rose(host_bus_clock) && edge_q != 3'h7) begin
            edge_q <= edge_q + 3'h1;
        end
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    wait_low_a: assert property ($rose(strb) |-> ##[1:4] (wait_n_oe && !wait_n_o))
        else $error("wait not driven low after strobe fell");
    wait_float_a: assert property ($fell(strb) |-> ##[0:4] !wait_n_oe)
        else $error("wait not floated after strobe rose");
    wait_release_a: assert property (wait_n_oe && wait_n_o && !$past(wait_n_o) |-> edge_q >= 3'h4)
        else $error("wait released before fourth bus clock edge");
    data_drive_a: assert property ($rose(dev_data_oe) |-> rstrb)
        else $error("read data driven without read strobe");
    data_float_a: assert property ($fell(rstrb) |-> ##[0:5] !dev_data_oe)
        else $error("read data still driven after strobe rose");
    hold_strobe_a: assert property ($fell(strb) |-> $past(wait_n))
        else $error("strobe rose while wait low");
    strobe_gap_a: assert property ($fell(strb) |-> !strb [*8])
        else $error("strobes reasserted within one bus clock");
    addr_hold_a: assert property (strb && $past(strb) |->
        $stable(addr) && $stable(cs_n) && $stable(mem_reg_sel) && $stable(high_byte_enable_n))
        else $error("address or select moved during strobe");
    cs_qual_a: assert property (strb |-> !cs_n)
        else $error("strobe low without chip select");
endmodule : ghp_asserts

//--- dv/testbench.sv
// Self-checking bench joining host and device ends of the generic host bus port.
// Assumes the design sources under src are compiled first.
`timescale 1ns/100ps
module testbench;
    import ghp_pkg::*;
    logic i_mclk, i_rst, big, req, wr, msel, d_req, d_wr, d_msel, ack, busy, done;
    ghp_mode_t mode;
    logic [16:0] addr;
    logic [1:0] be, d_be;
    logic [15:0] wdata, rdata, d_addr, d_wdata, ack_rdata;
    logic e_wr, e_msel;
    logic [1:0] e_be;
    logic [15:0] e_addr, e_wdata;
    logic [15:0] mem [int];
    int failures = 0;
    int comparisons = 0;
    int seed = 92341;
    ghp_if bus_if();

    ghp_host ghp_host_inst (.i_mclk(i_mclk), .i_rst(i_rst), .bus(bus_if.host), .i_mode(mode),
        .i_big_endian(big), .i_req(req), .i_wr(wr), .i_addr(addr), .i_mem_sel(msel), .i_be(be),
        .i_wdata(wdata), .o_busy_q(busy), .o_done_q(done), .o_rdata_q(rdata));
    ghp_device ghp_device_inst (.i_mclk(i_mclk), .i_rst(i_rst), .bus(bus_if.dev), .i_mode(mode),
        .i_big_endian(big), .o_req_q(d_req), .o_wr_q(d_wr), .o_addr_q(d_addr), .o_mem_sel_q(d_msel),
        .o_be_q(d_be), .o_wdata_q(d_wdata), .i_ack(ack), .i_rdata(ack_rdata));
    ghp_asserts ghp_asserts_inst (.i_mclk(i_mclk), .i_rst(i_rst), .host_bus_clock(bus_if.host_bus_clock),
        .cs_n(bus_if.cs_n), .addr(bus_if.addr), .mem_reg_sel(bus_if.mem_reg_sel),
        .high_byte_enable_n(bus_if.high_byte_enable_n), .read_strobe_lo_n(bus_if.read_strobe_lo_n),
        .read_strobe_hi_n(bus_if.read_strobe_hi_n), .write_strobe_lo_n(bus_if.write_strobe_lo_n),
        .write_strobe_hi_n(bus_if.write_strobe_hi_n), .read_n(bus_if.read_n), .write_n(bus_if.write_n),
        .wait_n_o(bus_if.wait_n_o), .wait_n_oe(bus_if.wait_n_oe), .dev_data_oe(bus_if.dev_data_oe),
        .wait_n(bus_if.wait_n));

    always #50 i_mclk = ~i_mclk;

    // ------------------------------------------------------------------------
    // Model and comparisons
    // ------------------------------------------------------------------------
    function automatic logic [15:0] rdm(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : 16'h0000;
    endfunction : rdm

    function automatic logic [15:0] lm(input logic [1:0] b);
        return {{8{b[1]}}, {8{b[0]}}};
    endfunction : lm

    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk

    task automatic check_req();
        chk("req wr", 17'(e_wr), 17'(d_wr));
        chk("req addr", 17'(e_addr), 17'(d_addr));
        chk("req sel", 17'(e_msel), 17'(d_msel));
        chk("req lanes", 17'(e_be), 17'(d_be));
        if (e_wr) chk("req wdata", 17'(e_wdata & lm(e_be)), 17'(d_wdata & lm(e_be)));
    endtask : check_req

    task automatic check_pin();
        logic a0;
        a0 = bus_if.addr[0];
        if (mode == GHP_MODE_SPLIT) begin
            chk("split pins", {12'h0, big ? e_be == 2'h1 : e_be == 2'h2, e_wr ? {2'h3, ~e_be} : {~e_be, 2'h3}},
                {12'h0, a0, bus_if.read_strobe_hi_n, bus_if.read_strobe_lo_n, bus_if.write_strobe_hi_n,
                bus_if.write_strobe_lo_n});
        end else begin
            chk("single pins", {13'h0, e_be == 2'h2, ~e_be[1], e_wr, ~e_wr},
                {13'h0, a0, bus_if.high_byte_enable_n, bus_if.read_n, bus_if.write_n});
        end
    endtask : check_pin

    task automatic check_rd(input logic [15:0] e, input logic [15:0] g);
        chk("read data", 17'(e), 17'(g));
    endtask : check_rd

    task automatic stop_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------------------
    // Internal side of the device: memory answering with random latency
    // ------------------------------------------------------------------------
    initial begin
        int lat;
        {ack, ack_rdata} = '0;
        forever begin
            @(posedge i_mclk);
            #1;
            if (d_req === 1'h1) begin
                check_req();
                check_pin();
                if (e_wr) mem[e_addr] = (rdm(e_addr) & ~lm(e_be)) | (e_wdata & lm(e_be));
                lat = 1 + ($unsigned($random(seed)) % 4);
                repeat (lat) @(posedge i_mclk);
                #1;
                ack = 1'h1;
                ack_rdata = rdm(e_addr);
                @(posedge i_mclk);
                #1;
                ack = 1'h0;
                ack_rdata = ~ack_rdata;
            end
        end
    end

    task automatic access(input logic w, input logic [16:0] a, input logic [1:0] b, input logic [15:0] d,
        input logic s);
        int n;
        logic [15:0] x;
        e_wr = w;
        e_addr = a[16:1];
        e_be = b;
        e_wdata = d;
        e_msel = s;
        x = rdm(a[16:1]) & lm(b);
        @(posedge i_mclk);
        #1;
        {req, wr, addr, be, wdata, msel} = {1'h1, w, a, b, d, s};
        @(posedge i_mclk);
        #1;
        req = 1'h0;
        chk("host busy", 17'h1, 17'(busy));
        n = 0;
        while (done !== 1'h1 && n < 2000) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        if (n >= 2000) failures++;
        chk("host idle", 17'h0, 17'(busy));
        if (!w) check_rd(x, rdata & lm(b));
        chk("wait idle", 17'h1, 17'(bus_if.wait_n));
    endtask : access

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [1:0] rb;
        {i_mclk, i_rst, big, req, wr, msel} = 6'h10;
        {addr, be, wdata} = '0;
        mode = GHP_MODE_SPLIT;
        repeat (8) @(posedge i_mclk);
        #1 i_rst = 1'h0;
        repeat (2) @(posedge i_mclk);
        for (int k = 0; k < 30; k++) begin
            if (k == 15) begin
                @(posedge i_mclk) #1 i_rst = 1'h1;
                repeat (3) @(posedge i_mclk);
                #1 i_rst = 1'h0;
                repeat (2) @(posedge i_mclk);
            end
            r = $random(seed);
            mode = ghp_mode_t'(k[0]);
            big = k[1];
            rb = (r[1:0] == 2'h0) ? 2'h3 : r[1:0];
            access(1'h1, r[24:8], 2'(k % 3) + 2'h1, r[31:16], r[5]);
            access(1'h0, {r[24:9], r[2]}, rb, 16'h0000, r[5]);
        end
        stop_test();
    end

    initial begin
        #(100 * 30000);
        failures++;
        stop_test();
    end
endmodule : testbench
